/* File: src/uarx_consts.svh */
/*
 * constants for the asynchronous receive front end: register offsets,
 * field positions, reset values and sample-state timing.
 * assumes inclusion by bare name from the receiver and bench files.
 */
`ifndef UARX_CONSTS_SVH
`define UARX_CONSTS_SVH

// register byte offsets on the avalon slave
`define UARX_OFF_CTRL     4'h0
`define UARX_OFF_STATUS   4'h4
`define UARX_OFF_DATA     4'h8
`define UARX_OFF_DIV      4'hc

// control field positions
`define UARX_CTRL_RXEN    0
`define UARX_CTRL_DBL     1
`define UARX_CTRL_SDET    2
`define UARX_CTRL_SIRQ    3
`define UARX_CTRL_PAR     4
`define UARX_CTRL_NB_LO   5
`define UARX_CTRL_NB_HI   8

// status field positions
`define UARX_ST_RXC       0
`define UARX_ST_FERR      1
`define UARX_ST_START     2
`define UARX_ST_WAKE      3
`define UARX_ST_BUSY      4

// reset values
`define UARX_CTRL_RST     9'h101
`define UARX_DIV_RST      16'h0000

// sample states per bit and voting samples
`define UARX_SPB_NORM     5'h10
`define UARX_SPB_DBL      5'h08
`define UARX_VOTE_NORM    5'h08
`define UARX_VOTE_DBL     5'h04
`define UARX_DATA_MAX     4'h9

`endif

/* File: src/uarx_pkg.sv */
/*
 * types shared by the receive front end.
 * assumes the constants header sits beside it.
 */
package uarx_pkg;
	typedef enum logic [3:0] {
		UARX_IDLE  = 4'b0001,
		UARX_START = 4'b0010,
		UARX_BITS  = 4'b0100,
		UARX_STOP  = 4'b1000
	} uarx_state_e;
endpackage : uarx_pkg

/* File: src/uarx_tick_if.sv */
/*
 * interface carrying the sample tick from the divider to the receiver.
 * assumes one clock domain.
 */
`timescale 1ns/1ns
interface uarx_tick_if;
	logic        tick;
	logic [15:0] divisor;
	logic        run;
	modport gen (input divisor, input run, output tick);
	modport use_ (output divisor, output run, input tick);
endinterface : uarx_tick_if

/* File: src/uarx_tick_gen.sv */
/*
 * sample tick divider: one-cycle enable every divisor+1 clocks.
 * assumes divisor is held stable while run is high.
 */
`timescale 1ns/1ns
module uarx_tick_gen (
	input  wire logic CLK,
	input  wire logic RST,
	uarx_tick_if.gen  tif
);
	logic [15:0] cnt_reg;
	logic        tick_reg;

	// counter restarts whenever run is low
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (!tif.run) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (cnt_reg >= tif.divisor) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg  <= cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end
	assign tif.tick = tick_reg;
endmodule : uarx_tick_gen

/* File: src/uarx_rx.sv */
/*
 * asynchronous receive front end: start qualification, three-sample
 * majority bit recovery, framing check, start frame detector and
 * a one-deep result register on an avalon-mm slave with waitrequest.
 * assumes RXD is already synchronous to CLK and idles high.
 */
`timescale 1ns/1ns
`include "uarx_consts.svh"

module uarx_rx (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        RXD,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             START_IRQ,
	output logic             OSC_WAKE,
	output logic             RX_DONE
);
	uarx_tick_if tif ();

	logic [8:0]  ctrl_reg;
	logic [15:0] div_reg;
	uarx_pkg::uarx_state_e st_reg;
	logic [4:0]  samp_reg;
	logic [1:0]  votes_reg;
	logic [3:0]  bit_reg;
	logic [9:0]  shift_reg;
	logic        prev_reg;
	logic        armed_reg;
	logic [9:0]  data_reg;
	logic        ferr_reg;
	logic        rxc_reg;
	logic        sirq_reg;
	logic        wake_reg;
	logic        done_reg;
	logic        ack_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;

	logic        dbl;
	logic [4:0]  spb;
	logic [4:0]  vfirst;
	logic [3:0]  nbits;
	logic        tick;
	logic        fall;
	logic        in_vote;
	logic        last_vote;
	logic        maj;
	logic        rd_data;

	// majority of two stored votes plus the current sample
	function automatic logic vote3(input logic [1:0] v, input logic s);
		vote3 = (v[0] & v[1]) | (s & (v[0] | v[1]));
	endfunction : vote3

	assign dbl    = ctrl_reg[`UARX_CTRL_DBL];
	assign spb    = dbl ? `UARX_SPB_DBL : `UARX_SPB_NORM;
	assign vfirst = dbl ? `UARX_VOTE_DBL : `UARX_VOTE_NORM;
	assign nbits  = (ctrl_reg[`UARX_CTRL_NB_HI:`UARX_CTRL_NB_LO] > `UARX_DATA_MAX) ?
		`UARX_DATA_MAX : ctrl_reg[`UARX_CTRL_NB_HI:`UARX_CTRL_NB_LO];
	assign tick   = tif.tick;
	// edge needs a high sample first, so a stuck low line never restarts
	assign fall      = armed_reg & prev_reg & ~RXD;
	assign in_vote   = (samp_reg >= vfirst) && (samp_reg <= vfirst + 5'h02);
	assign last_vote = samp_reg == vfirst + 5'h02;
	assign maj       = vote3(votes_reg, RXD);
	assign rd_data   = AVS_READ && !ack_reg && AVS_ADDRESS == `UARX_OFF_DATA;

	// the divider only runs while the receiver is enabled; the detector needs it too
	assign tif.divisor = div_reg;
	assign tif.run     = ctrl_reg[`UARX_CTRL_RXEN];

	uarx_tick_gen u_tick (
		.CLK (CLK),
		.RST (RST),
		.tif (tif)
	);

	// edge tracking on sample ticks; armed by the first high sample after reset, never cleared
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			prev_reg  <= 1'b1;
			armed_reg <= 1'b0;
		end else if (tick) begin
			prev_reg  <= RXD;
			armed_reg <= armed_reg | RXD;
		end
	end

	// receive sequencer
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_reg    <= uarx_pkg::UARX_IDLE;
			samp_reg  <= 5'h00;
			votes_reg <= 2'h0;
			bit_reg   <= 4'h0;
			shift_reg <= 10'h000;
		end else if (!ctrl_reg[`UARX_CTRL_RXEN]) begin
			// disabling drops any frame in flight
			st_reg <= uarx_pkg::UARX_IDLE;
		end else if (tick) begin
			unique case (st_reg)
				uarx_pkg::UARX_IDLE: begin
					// first low sample is sample one
					// accepted as soon as the stop vote is done
					if (fall) begin
						st_reg   <= uarx_pkg::UARX_START;
						samp_reg <= 5'h02;
					end
					votes_reg <= 2'h0;
				end
				uarx_pkg::UARX_START: begin
					samp_reg <= samp_reg + 5'h01;
					if (in_vote) begin
						votes_reg <= {votes_reg[0], RXD};
					end
					if (last_vote) begin
						if (maj) begin
							st_reg <= uarx_pkg::UARX_IDLE;
						end
					end
					// bit timing restarts from this start bit
					if (samp_reg == spb) begin
						st_reg   <= uarx_pkg::UARX_BITS;
						samp_reg <= 5'h01;
						bit_reg  <= 4'h0;
					end
				end
				uarx_pkg::UARX_BITS: begin
					// one state per sample within the bit
					samp_reg <= (samp_reg == spb) ? 5'h01 : samp_reg + 5'h01;
					if (in_vote) begin
						votes_reg <= {votes_reg[0], RXD};
					end
					if (last_vote) begin
						shift_reg[bit_reg] <= maj;
					end
					if (samp_reg == spb) begin
						bit_reg <= bit_reg + 4'h1;
						if (bit_reg + 4'h1 == nbits + {3'h0, ctrl_reg[`UARX_CTRL_PAR]}) begin
							st_reg <= uarx_pkg::UARX_STOP;
						end
					end
				end
				uarx_pkg::UARX_STOP: begin
					samp_reg <= samp_reg + 5'h01;
					if (in_vote) begin
						votes_reg <= {votes_reg[0], RXD};
					end
					// only the first stop bit is looked at
					if (last_vote) begin
						st_reg <= uarx_pkg::UARX_IDLE;
					end
				end
			endcase
		end
	end

	// completed frame result, error kept with its data
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			data_reg <= 10'h000;
			ferr_reg <= 1'b0;
			rxc_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (tick && st_reg == uarx_pkg::UARX_STOP && last_vote &&
			    ctrl_reg[`UARX_CTRL_RXEN]) begin
				data_reg <= shift_reg;
				ferr_reg <= ~maj;
				rxc_reg  <= 1'b1;
				done_reg <= 1'b1;
			end else if (rd_data) begin
				rxc_reg <= 1'b0;
			end
		end
	end

	// start frame detector: wake and start interrupt
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sirq_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			// start edge wakes oscillator and port clock
			if (ctrl_reg[`UARX_CTRL_SDET] && tick && st_reg == uarx_pkg::UARX_IDLE && fall) begin
				wake_reg <= 1'b1;
			// clocks held only while the frame is received
			end else if (st_reg == uarx_pkg::UARX_IDLE && !(tick && fall)) begin
				wake_reg <= 1'b0;
			end
			// raised at once on the edge; set wins over clear
			if (ctrl_reg[`UARX_CTRL_SDET] && ctrl_reg[`UARX_CTRL_SIRQ] && tick &&
			    st_reg == uarx_pkg::UARX_IDLE && fall) begin
				sirq_reg <= 1'b1;
			end else if (AVS_WRITE && !ack_reg && AVS_ADDRESS == `UARX_OFF_STATUS &&
			             AVS_WRITEDATA[`UARX_ST_START]) begin
				sirq_reg <= 1'b0;
			end
		end
	end

	// avalon slave: every access waits one cycle, then completes
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_reg  <= `UARX_CTRL_RST;
			div_reg   <= `UARX_DIV_RST;
			ack_reg   <= 1'b0;
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
			wait_reg <= ~((AVS_READ | AVS_WRITE) & ~ack_reg);
			if (AVS_WRITE && !ack_reg) begin
				unique case (AVS_ADDRESS)
					`UARX_OFF_CTRL: ctrl_reg <= AVS_WRITEDATA[8:0];
					`UARX_OFF_DIV:  div_reg  <= AVS_WRITEDATA[15:0];
					default: ;
				endcase
			end
			if (AVS_READ && !ack_reg) begin
				unique case (AVS_ADDRESS)
					`UARX_OFF_CTRL:   rdata_reg <= {23'h000000, ctrl_reg};
					`UARX_OFF_STATUS: rdata_reg <= {27'h0000000,
						st_reg != uarx_pkg::UARX_IDLE, wake_reg, sirq_reg, ferr_reg, rxc_reg};
					`UARX_OFF_DATA:   rdata_reg <= {21'h000000, ferr_reg, data_reg};
					`UARX_OFF_DIV:    rdata_reg <= {16'h0000, div_reg};
					default:          rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	assign AVS_WAITREQUEST = wait_reg;
	assign AVS_READDATA    = rdata_reg;
	assign START_IRQ       = sirq_reg;
	assign OSC_WAKE        = wake_reg;
	assign RX_DONE         = done_reg;

	// a start voted high never reaches bit recovery
	property p_reject;
		@(posedge CLK) disable iff (RST)
		(tick && st_reg == uarx_pkg::UARX_START && last_vote && maj) |=>
			st_reg == uarx_pkg::UARX_IDLE;
	endproperty
	a_reject: assert property (p_reject) else $error("noisy start accepted");

	// frame error follows the stop vote
	property p_ferr;
		@(posedge CLK) disable iff (RST)
		(tick && st_reg == uarx_pkg::UARX_STOP && last_vote && ctrl_reg[0]) |=>
			(ferr_reg == ~$past(maj)) && RX_DONE;
	endproperty
	a_ferr: assert property (p_ferr) else $error("frame error mismatch");

	// start irq one cycle after the edge
	property p_sirq;
		@(posedge CLK) disable iff (RST)
		(ctrl_reg[2] && ctrl_reg[3] && tick && st_reg == uarx_pkg::UARX_IDLE && fall &&
		 ctrl_reg[0]) |=> START_IRQ && OSC_WAKE;
	endproperty
	a_sirq: assert property (p_sirq) else $error("start irq missing");

	// no wake with the detector off
	property p_nowake;
		@(posedge CLK) disable iff (RST)
		(!ctrl_reg[2] && !OSC_WAKE) |=> !OSC_WAKE;
	endproperty
	a_nowake: assert property (p_nowake) else $error("wake without enable");

	// sample state never passes the bit length
	property p_samp;
		@(posedge CLK) disable iff (RST)
		st_reg == uarx_pkg::UARX_BITS |-> samp_reg <= spb && samp_reg != 5'h00;
	endproperty
	a_samp: assert property (p_samp) else $error("sample state out of range");

	// idle to start lands on sample two
	property p_start;
		@(posedge CLK) disable iff (RST)
		(st_reg == uarx_pkg::UARX_IDLE && $past(st_reg) == uarx_pkg::UARX_IDLE) ##1
			st_reg == uarx_pkg::UARX_START |-> samp_reg == 5'h02;
	endproperty
	a_start: assert property (p_start) else $error("start count wrong");

	// leaving idle needs an armed edge
	property p_arm;
		@(posedge CLK) disable iff (RST)
		(st_reg == uarx_pkg::UARX_IDLE && ctrl_reg[0] && !(tick && fall)) |=>
			st_reg == uarx_pkg::UARX_IDLE;
	endproperty
	a_arm: assert property (p_arm) else $error("start without edge");

	// wake drops once back in idle without a new edge
	sequence s_end;
		st_reg != uarx_pkg::UARX_IDLE ##1 st_reg == uarx_pkg::UARX_IDLE && !(tick && fall);
	endsequence
	property p_sleep;
		@(posedge CLK) disable iff (RST)
		s_end |=> !OSC_WAKE;
	endproperty
	a_sleep: assert property (p_sleep) else $error("clock left running");
endmodule : uarx_rx

/* File: test/uarx_tx_model.sv */
/*
 * remote serial sender model that drives the receive line.
 * assumes every task is entered just after a rising clock edge.
 */
`timescale 1ns/1ns
module uarx_tx_model (
	input  wire logic clk,
	output logic      rxd
);
	int cps = 2; // clocks per receiver sample, left at 2 by the bench

	// line idles high until the first frame
	initial rxd = 1'b1;

	// hold the line at one level for a number of samples
	task automatic hold(input logic v, input int smp);
		rxd <= v;
		repeat (smp * cps) @(posedge clk);
	endtask : hold

	// exact rate at the given samples per bit
	// start, bits lsb first, first stop; an exact rate leaves the
	// whole error budget to the receiver
	task automatic send(input logic [9:0] b, input int nb, input int spb,
		input logic stop_v, input int stop_smp);
		hold(1'b0, spb);
		for (int i = 0; i < nb; i++) begin
			hold(b[i], spb);
		end
		hold(stop_v, stop_smp);
	endtask : send
endmodule : uarx_tx_model

/* File: test/uarx_rx_tb_top.sv */
/*
 * self-checking bench for the receive front end: random frames in
 * five formats, noise starts, breaks, back-to-back frames, detector.
 * assumes the constants header is on the include path.
 */
`timescale 1ns/1ns
`include "uarx_consts.svh"
module uarx_rx_tb_top;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        rxd;
	logic [3:0]  addr      = 4'h0;
	logic        rd_en     = 1'b0;
	logic        wr_en     = 1'b0;
	logic [31:0] wdata     = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic        start_irq;
	logic        osc_wake;
	logic        rx_done;
	int          wake_cnt  = 0;
	int          w0;
	logic [31:0] v;
	int          n_fail    = 0;
	int          cmp_count = 0;
	int          done_cnt  = 0;
	int          d0;
	int          spb;
	logic [31:0] ctl [5]   = '{32'h101, 32'h103, 32'h111, 32'h0a1, 32'h123};
	int          nbs [5]   = '{8, 8, 9, 5, 9};

	always #5 clk = ~clk;

	uarx_rx dut (.CLK(clk), .RST(rst), .RXD(rxd), .AVS_ADDRESS(addr),
		.AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.START_IRQ(start_irq), .OSC_WAKE(osc_wake), .RX_DONE(rx_done));

	uarx_tx_model tx (.clk(clk), .rxd(rxd));

	// count completion pulses; a pulse counts once for every cycle it is high
	always @(posedge clk) begin
		if (rx_done === 1'b1) done_cnt <= done_cnt + 1;
		if (osc_wake === 1'b1) wake_cnt <= wake_cnt + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("compares=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// avalon master: hold the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		addr <= a;
		wdata <= wd;
		wr_en <= wr;
		rd_en <= !wr;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		rd = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : bus

	// mask of the data word: frame bits plus the frame error bit
	function automatic logic [31:0] fmask(input int nb);
		return {21'h0, 1'b1, 10'h3ff >> (10 - nb)};
	endfunction : fmask

	// one frame, a tail of the stop level, idle, then result checks
	task automatic frame(input int nb, input logic [9:0] b, input logic stop_v,
		input int tail);
		d0 = done_cnt;
		tx.send(b, nb, spb, stop_v, spb);
		tx.hold(stop_v, tail + 1);
		tx.hold(1'b1, 2 * spb);
		check(32'(done_cnt - d0), 32'h1);
		bus(1'b0, `UARX_OFF_STATUS, 32'h0, v);
		check(v & 32'h3, {30'h0, ~stop_v, 1'b1});
		bus(1'b0, `UARX_OFF_DATA, 32'h0, v);
		check(v & fmask(nb), {21'h0, ~stop_v, b} & fmask(nb));
		bus(1'b0, `UARX_OFF_STATUS, 32'h0, v);
		check(v & 32'h1, 32'h0);
	endtask : frame

	// a hang counts as a mismatch; about four and a half times the expected run
	initial begin
		#600000;
		n_fail++;
		complete_run();
	end

	initial begin
		v = $urandom(32);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, `UARX_OFF_CTRL, 32'h0, v);
		check(v, 32'h101);
		bus(1'b0, `UARX_OFF_DIV, 32'h0, v);
		check(v, 32'h0);
		bus(1'b1, 4'h2, 32'hffff_ffff, v);
		bus(1'b0, 4'h2, 32'h0, v);
		check(v, 32'h0);
		bus(1'b0, `UARX_OFF_CTRL, 32'h0, v);
		check(v, 32'h101);
		// divisor 1: one sample every two clocks
		bus(1'b1, `UARX_OFF_DIV, 32'h1, v);
		bus(1'b0, `UARX_OFF_DIV, 32'h0, v);
		check(v, 32'h1);
		// five formats: corner and random frames, noise start, break
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, `UARX_OFF_CTRL, ctl[k], v);
			spb = ctl[k][1] ? 8 : 16;
			for (int i = 0; i < 5; i++)
				frame(nbs[k], (i == 0) ? 10'h3ff : 10'($urandom), 1'b1, 0);
			d0 = done_cnt;
			// idle long enough that a wrongly accepted start would complete
			tx.hold(1'b0, spb / 2 - 3);
			tx.hold(1'b1, 13 * spb);
			check(32'(done_cnt - d0), 32'h0);
			frame(nbs[k], 10'h000, 1'b0, 3 * spb);
		end
		check(32'(wake_cnt), 32'h0);
		// next start right after the stop voting samples; the second frame wins
		bus(1'b1, `UARX_OFF_CTRL, 32'h101, v);
		spb = 16;
		d0 = done_cnt;
		tx.send(10'h0a5, 8, 16, 1'b1, 10);
		tx.send(10'h05a, 8, 16, 1'b1, 16);
		tx.hold(1'b1, 2 * spb);
		check(32'(done_cnt - d0), 32'h2);
		bus(1'b0, `UARX_OFF_STATUS, 32'h0, v);
		check(v & 32'h13, 32'h1);
		bus(1'b0, `UARX_OFF_DATA, 32'h0, v);
		check(v & fmask(8), 32'h05a);
		bus(1'b0, `UARX_OFF_STATUS, 32'h0, v);
		check(v & 32'h1, 32'h0);
		check({31'h0, start_irq}, 32'h0);
		// detector with start interrupt
		bus(1'b1, `UARX_OFF_CTRL, 32'h10d, v);
		w0 = wake_cnt;
		frame(8, 10'($urandom), 1'b1, 0);
		check({31'h0, start_irq}, 32'h1);
		check({30'h0, osc_wake, wake_cnt != w0}, 32'h1);
		bus(1'b0, `UARX_OFF_STATUS, 32'h0, v);
		check(v & 32'h4, 32'h4);
		bus(1'b1, `UARX_OFF_STATUS, 32'h4, v);
		check({31'h0, start_irq}, 32'h0);
		// detector without start interrupt
		bus(1'b1, `UARX_OFF_CTRL, 32'h105, v);
		w0 = wake_cnt;
		frame(8, 10'($urandom), 1'b1, 0);
		check({30'h0, start_irq, wake_cnt != w0}, 32'h1);
		complete_run();
	end
endmodule : uarx_rx_tb_top
